// *** verilog/uirq_pkg.sv ***
// Purpose: constants and types for the serial port interrupt block
// Assumes: apb slave, 32-bit data, one clock pclk at 10 MHz
// Notes: How it works list follows
// How it works
// - parity mismatch sets parity error when enabled
// - parity error held in status until the next word's parity check
// - six conditions can raise serial interrupt
// - active-low pulse on interrupt request output
// - vector needs global, unit enable, stack room
// - tx enables separate, rx pair shares enable
// - address detect interrupts directly, no flag
// - rx falling edge wakes when clock off
// - flags read-only, cleared by uart actions
// - address mode needs top bit set
// - no address mode, every word interrupts
// - clock stop pauses transfers, resumes later
// - idle or sleep leaves registers unchanged
// - rx data ignored during start-up delay
// - wake without global enables raises no interrupt
// - interrupt held off until start-up elapses
// - rx flag clears on status then data read
// - overrun interrupts under shared rx enable
// - nine-bit mode stores extra bit in control
package uirq_pkg;
    // register byte addresses
    localparam logic [7:0] UIRQ_STATUS_ADDR = 8'h00;
    localparam logic [7:0] UIRQ_CTRL1_ADDR = 8'h04;
    localparam logic [7:0] UIRQ_CTRL2_ADDR = 8'h08;
    localparam logic [7:0] UIRQ_DATA_ADDR = 8'h0C;
    localparam logic [7:0] UIRQ_BAUD_ADDR = 8'h10;
    localparam logic [7:0] UIRQ_SYS_ADDR = 8'h14;
    // status bit positions
    localparam int UIRQ_ST_PERR = 0;
    localparam int UIRQ_ST_FERR = 1;
    localparam int UIRQ_ST_OERR = 2;
    localparam int UIRQ_ST_RXAV = 3;
    localparam int UIRQ_ST_TXE = 4;
    localparam int UIRQ_ST_TIDLE = 5;
    localparam int UIRQ_ST_WAKE = 6;
    // control one bit positions
    localparam int UIRQ_C1_MODE = 0;
    localparam int UIRQ_C1_UEN = 1;
    localparam int UIRQ_C1_NINE = 2;
    localparam int UIRQ_C1_PEN = 3;
    localparam int UIRQ_C1_PODD = 4;
    localparam int UIRQ_C1_BIT8 = 5;
    // control two bit positions
    localparam int UIRQ_C2_RXEN = 0;
    localparam int UIRQ_C2_ADDEN = 1;
    localparam int UIRQ_C2_WAKE = 2;
    localparam int UIRQ_C2_RIE = 3;
    localparam int UIRQ_C2_TIIE = 4;
    localparam int UIRQ_C2_TEIE = 5;
    // system register bit positions
    localparam int UIRQ_SY_GIE = 0;
    localparam int UIRQ_SY_UIE = 1;
    localparam int UIRQ_SY_STKF = 2;
    localparam int UIRQ_SY_CLKOFF = 3;
    localparam logic [7:0] UIRQ_REG_RESET = 8'h00;
    localparam logic [15:0] UIRQ_BAUD_RESET = 16'h0000;
    // start-up delay after rx wake-up
    localparam int UIRQ_STARTUP_US = 100;
    localparam int UIRQ_CLK_MHZ = 10;
    localparam int UIRQ_STARTUP_CYC = UIRQ_STARTUP_US * UIRQ_CLK_MHZ;
    localparam int UIRQ_OVS = 16;

    typedef enum logic [3:0] {
        UIRQ_IDLE = 4'b0001,
        UIRQ_START = 4'b0010,
        UIRQ_DATA = 4'b0100,
        UIRQ_STOP = 4'b1000
    } uirq_rx_state_type;

    typedef struct packed {
        logic [8:0] data;
        logic perr;
        logic ferr;
    } uirq_word_type;
endpackage

// *** verilog/uirq_top.sv ***
// Purpose: uart receiver with merged interrupt, address detect and wake
// Assumes: inputs synchronous to pclk; tx side reports via tx_empty_in
// Notes: uart clock presence is the clock-off bit, which gates all
//        baud activity rather than the real clock
module uirq_top #(
    parameter int STARTUP_CYC = uirq_pkg::UIRQ_STARTUP_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_in,
    input wire logic tx_empty_in,
    input wire logic tx_idle_in,
    output logic irq_n,
    output logic vector_req,
    output logic wake_out
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] status_q;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [15:0] baud_q;
    logic [3:0] sys_q;
    uirq_pkg::uirq_word_type buf_q [2];
    logic [1:0] cnt_q;
    logic stat_seen_q;
    logic rx_q;
    logic wake_q;
    logic [15:0] startup_q;
    logic [15:0] bdiv_q;
    logic [3:0] ovs_q;
    logic [3:0] bit_q;
    logic [8:0] sh_q;
    logic par_q;
    uirq_pkg::uirq_rx_state_type st_q;
    logic word_done;
    logic oerr_ev;
    logic addr_ev;
    logic rd_data;
    logic rd_stat;
    logic wr;
    logic tick;
    logic clk_run;
    logic [3:0] nbits;
    logic rx_ok;
    logic irq_any;
    logic irq_prev_q;
    logic perr_now;
    logic irq_fire;
    logic wake_pend_q;
    uirq_pkg::uirq_word_type new_word;

    ////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states
    assign wr = psel && penable && pwrite;
    assign rd_data = psel && penable && !pwrite
        && paddr == uirq_pkg::UIRQ_DATA_ADDR;
    assign rd_stat = psel && penable
        && paddr == uirq_pkg::UIRQ_STATUS_ADDR;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (paddr == uirq_pkg::UIRQ_STATUS_ADDR) begin
                    prdata <= {24'h000000, status_q};
                end else if (paddr == uirq_pkg::UIRQ_CTRL1_ADDR) begin
                    prdata <= {24'h000000, ctrl1_q};
                end else if (paddr == uirq_pkg::UIRQ_CTRL2_ADDR) begin
                    prdata <= {24'h000000, ctrl2_q};
                end else if (paddr == uirq_pkg::UIRQ_DATA_ADDR) begin
                    prdata <= {24'h000000, buf_q[0].data[7:0]};
                end else if (paddr == uirq_pkg::UIRQ_BAUD_ADDR) begin
                    prdata <= {16'h0000, baud_q};
                end else if (paddr == uirq_pkg::UIRQ_SYS_ADDR) begin
                    prdata <= {28'h0000000, sys_q};
                end else begin
                    pslverr <= psel && !penable;
                end
            end else if (psel && !penable) begin
                if (paddr > uirq_pkg::UIRQ_SYS_ADDR || paddr[1:0] != 2'b00)
                begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // control writes; clock stop and sleep never touch them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl2_q <= uirq_pkg::UIRQ_REG_RESET;
            baud_q <= uirq_pkg::UIRQ_BAUD_RESET;
            sys_q <= 4'h0;
        end else if (wr && pready) begin
            if (paddr == uirq_pkg::UIRQ_CTRL2_ADDR) begin
                ctrl2_q <= pwdata[7:0];
            end else if (paddr == uirq_pkg::UIRQ_BAUD_ADDR) begin
                baud_q <= pwdata[15:0];
            end else if (paddr == uirq_pkg::UIRQ_SYS_ADDR) begin
                sys_q <= pwdata[3:0];
            end
        end
    end

    // bit 8 of control one follows the head word in nine-bit mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_q <= uirq_pkg::UIRQ_REG_RESET;
        end else if (wr && pready && paddr == uirq_pkg::UIRQ_CTRL1_ADDR)
        begin
            ctrl1_q <= {pwdata[7:6], ctrl1_q[5], pwdata[4:0]};
        end else begin
            ctrl1_q[uirq_pkg::UIRQ_C1_BIT8] <= buf_q[0].data[8];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // baud enable: halts whenever the uart clock is off
    assign clk_run = !sys_q[uirq_pkg::UIRQ_SY_CLKOFF];
    assign tick = clk_run && bdiv_q == 16'h0000;
    assign rx_ok = clk_run && startup_q == 16'h0000
        && ctrl1_q[uirq_pkg::UIRQ_C1_UEN] && ctrl2_q[uirq_pkg::UIRQ_C2_RXEN];
    assign nbits = ctrl1_q[uirq_pkg::UIRQ_C1_NINE] ? 4'h9 : 4'h8;
    assign perr_now = ctrl1_q[uirq_pkg::UIRQ_C1_PEN]
        && (par_q ^ rx_in ^ ctrl1_q[uirq_pkg::UIRQ_C1_PODD]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bdiv_q <= 16'h0000;
        end else if (clk_run) begin
            bdiv_q <= tick ? baud_q : bdiv_q - 16'h0001;
        end
    end

    // receiver: samples mid-bit; pauses, not aborts, on clock stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= uirq_pkg::UIRQ_IDLE;
            ovs_q <= 4'h0;
            bit_q <= 4'h0;
            sh_q <= 9'h000;
            par_q <= 1'b0;
        end else if (tick) begin
            ovs_q <= ovs_q + 4'h1;
            case (st_q)
                uirq_pkg::UIRQ_IDLE: begin
                    ovs_q <= 4'h0;
                    if (!rx_in && rx_ok) begin
                        st_q <= uirq_pkg::UIRQ_START;
                    end
                end
                uirq_pkg::UIRQ_START: begin
                    if (ovs_q == 4'h7) begin
                        ovs_q <= 4'h0;
                        bit_q <= 4'h0;
                        par_q <= 1'b0;
                        st_q <= rx_in ? uirq_pkg::UIRQ_IDLE
                                      : uirq_pkg::UIRQ_DATA;
                    end
                end
                uirq_pkg::UIRQ_DATA: begin
                    if (ovs_q == 4'hF) begin
                        // parity bit is checked, never shifted into data
                        if (bit_q != nbits) begin
                            sh_q <= {rx_in, sh_q[8:1]};
                            par_q <= par_q ^ rx_in;
                        end
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == nbits - 4'h1
                            + {3'b000, ctrl1_q[uirq_pkg::UIRQ_C1_PEN]}) begin
                            st_q <= uirq_pkg::UIRQ_STOP;
                        end
                    end
                end
                default: begin
                    if (ovs_q == 4'hF) begin
                        st_q <= uirq_pkg::UIRQ_IDLE;
                    end
                end
            endcase
        end
    end

    assign word_done = tick && st_q == uirq_pkg::UIRQ_STOP && ovs_q == 4'hF;
    assign oerr_ev = word_done && cnt_q == 2'd2;
    // word as buffered; eight-bit words sit in the low bits
    assign new_word = '{ctrl1_q[uirq_pkg::UIRQ_C1_NINE] ? sh_q
        : {1'b0, sh_q[8:1]}, 1'b0, !rx_in};

    ////////////////////////////////////////////////////////////////////
    // two-word buffer with flags; status access then data read pops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 2'd0;
            stat_seen_q <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (rd_stat && pready) begin
                stat_seen_q <= 1'b1;
            end
            if (rd_data && pready && stat_seen_q && cnt_q != 2'd0) begin
                stat_seen_q <= 1'b0;
                buf_q[0] <= buf_q[1];
                cnt_q <= word_done ? cnt_q : cnt_q - 2'd1;
                // lone head leaving: the new word must become the head
                if (word_done && cnt_q == 2'd1) begin
                    buf_q[0] <= new_word;
                end else if (word_done) begin
                    buf_q[1] <= new_word;
                end
            end else if (word_done && cnt_q != 2'd2) begin
                cnt_q <= cnt_q + 2'd1;
                buf_q[cnt_q[0]] <= new_word;
            end
        end
    end

    // status: hardware-owned, read-only, never cleared by vectoring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= uirq_pkg::UIRQ_REG_RESET;
        end else begin
            status_q[uirq_pkg::UIRQ_ST_RXAV] <= cnt_q != 2'd0;
            status_q[uirq_pkg::UIRQ_ST_FERR] <= cnt_q != 2'd0
                && buf_q[0].ferr;
            status_q[uirq_pkg::UIRQ_ST_TXE] <= tx_empty_in;
            status_q[uirq_pkg::UIRQ_ST_TIDLE] <= tx_idle_in;
            status_q[uirq_pkg::UIRQ_ST_WAKE] <= startup_q != 16'h0000;
            if (tick && st_q == uirq_pkg::UIRQ_DATA && ovs_q == 4'hF
                && bit_q == nbits) begin
                status_q[uirq_pkg::UIRQ_ST_PERR] <= perr_now;
            end
            if (oerr_ev) begin
                status_q[uirq_pkg::UIRQ_ST_OERR] <= 1'b1; // set wins
            end else if (rd_data && pready && stat_seen_q) begin
                status_q[uirq_pkg::UIRQ_ST_OERR] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // rx wake: falling edge while clock off; then start-up count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= 1'b1;
            wake_q <= 1'b0;
            startup_q <= 16'h0000;
            wake_pend_q <= 1'b0;
        end else begin
            rx_q <= rx_in;
            wake_q <= 1'b0;
            if (!clk_run && rx_q && !rx_in
                && ctrl2_q[uirq_pkg::UIRQ_C2_WAKE]
                && ctrl1_q[uirq_pkg::UIRQ_C1_MODE]
                && ctrl1_q[uirq_pkg::UIRQ_C1_UEN]
                && ctrl2_q[uirq_pkg::UIRQ_C2_RXEN]
                && ctrl2_q[uirq_pkg::UIRQ_C2_RIE]) begin
                wake_q <= 1'b1;
                startup_q <= 16'(STARTUP_CYC);
            end else if (startup_q != 16'h0000) begin
                // start-up runs on the system clock, not the uart one
                startup_q <= startup_q - 16'h0001;
            end
            // wake interrupt waits out the start-up instead of being lost
            if (wake_q && sys_q[uirq_pkg::UIRQ_SY_GIE]
                && sys_q[uirq_pkg::UIRQ_SY_UIE]) begin
                wake_pend_q <= 1'b1;
            end else if (startup_q == 16'h0000) begin
                wake_pend_q <= 1'b0;
            end
        end
    end

    // address word: top received bit high
    assign addr_ev = word_done && (ctrl1_q[uirq_pkg::UIRQ_C1_NINE]
        ? sh_q[8] : sh_q[8]);

    // merge the six sources under their own enables
    assign irq_any =
        (status_q[uirq_pkg::UIRQ_ST_TXE] && ctrl2_q[uirq_pkg::UIRQ_C2_TEIE])
        || (status_q[uirq_pkg::UIRQ_ST_TIDLE]
            && ctrl2_q[uirq_pkg::UIRQ_C2_TIIE])
        || (ctrl2_q[uirq_pkg::UIRQ_C2_RIE] && word_done
            && !ctrl2_q[uirq_pkg::UIRQ_C2_ADDEN])
        || (ctrl2_q[uirq_pkg::UIRQ_C2_ADDEN] && addr_ev)
        || (ctrl2_q[uirq_pkg::UIRQ_C2_RIE] && oerr_ev)
        || (wake_pend_q && startup_q == 16'h0000);

    // new rising of the merged source, outside start-up
    assign irq_fire = irq_any && !irq_prev_q && startup_q == 16'h0000
        && !wake_q;

    // one low pulse per new qualifying event, after start-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_prev_q <= 1'b0;
            irq_n <= 1'b1;
            vector_req <= 1'b0;
            wake_out <= 1'b0;
        end else begin
            irq_prev_q <= irq_any;
            irq_n <= !irq_fire;
            vector_req <= irq_fire
                && sys_q[uirq_pkg::UIRQ_SY_GIE]
                && sys_q[uirq_pkg::UIRQ_SY_UIE]
                && !sys_q[uirq_pkg::UIRQ_SY_STKF];
            wake_out <= wake_q;
        end
    end
endmodule

// *** verif/uirq_assertions.sv ***
// Purpose: port-level checks for the serial interrupt block
// Assumes: enables are rebuilt from completed apb writes
// Notes: shadows follow the bus, so control one bit 8 changes by the block go unseen
module uirq_assertions #(
    parameter int STARTUP_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_empty_in,
    input wire logic tx_idle_in,
    input wire logic irq_n,
    input wire logic vector_req,
    input wire logic wake_out
);
    logic [7:0] c1_q;
    logic [7:0] c2_q;
    logic [7:0] sy_q;
    logic [1:0] quiet_q;
    logic wr_ok;
    assign wr_ok = psel && penable && pready && pwrite;
    ////////////////////////////////////////////////////////////////////////
    // shadow of the control and system registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q <= 8'h00;
            c2_q <= 8'h00;
            sy_q <= 8'h00;
        end else if (wr_ok) begin
            if (paddr == uirq_pkg::UIRQ_CTRL1_ADDR) c1_q <= pwdata[7:0];
            if (paddr == uirq_pkg::UIRQ_CTRL2_ADDR) c2_q <= pwdata[7:0];
            if (paddr == uirq_pkg::UIRQ_SYS_ADDR) sy_q <= pwdata[7:0];
        end
    end
    // cycles with all enables off; waits so a pending pulse may drain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quiet_q <= 2'h0;
        end else if ((c2_q & 8'h3E) != 8'h00) begin
            quiet_q <= 2'h0;
        end else if (quiet_q != 2'h3) begin
            quiet_q <= quiet_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_irq_one_cycle: assert property (
        !irq_n |=> irq_n) else $error("irq low too long");
    a_irq_all_masked: assert property (
        quiet_q == 2'h3 |-> irq_n) else $error("irq while masked");
    a_tx_empty_irq: assert property (
        c2_q == 8'h20 && !sy_q[3] && $rose(tx_empty_in) |-> ##[1:3] !irq_n)
        else $error("tx empty gave no irq");
    a_tx_idle_irq: assert property (
        c2_q == 8'h10 && !sy_q[3] && $rose(tx_idle_in) |-> ##[1:3] !irq_n)
        else $error("tx idle gave no irq");
    a_vector_gate: assert property (
        vector_req |-> sy_q[0] && sy_q[1] && !sy_q[2])
        else $error("vector without enables");
    a_vector_cause: assert property (
        vector_req |-> !irq_n || !$past(irq_n)) else $error("vector no irq");
    a_wake_cause: assert property (
        wake_out |-> (sy_q[3] || $past(sy_q[3])) && c2_q[3:2] == 2'h3
        && c2_q[0] && c1_q[1:0] == 2'h3) else $error("wake not enabled");
    a_wake_holdoff: assert property (
        wake_out |=> irq_n [*8]) else $error("irq during start-up");
    a_pready_answer: assert property (
        psel && !penable |=> pready) else $error("no pready");
    c_irq: cover property (!irq_n);
    c_vector: cover property (vector_req);
    c_wake: cover property (wake_out);
    c_slverr: cover property (pslverr);
endmodule

bind uirq_top uirq_assertions #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .tx_empty_in(tx_empty_in), .tx_idle_in(tx_idle_in),
    .irq_n(irq_n), .vector_req(vector_req), .wake_out(wake_out)
);

// *** verif/uirq_rx_driver.sv ***
// Purpose: remote serial transmitter driving the receive line
// Assumes: one bit lasts BIT_CYC clocks, lsb first, one stop bit
// Notes: line idles high between frames; gap sets prompt or slow starts
module uirq_rx_driver #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;
    // drive one level for n clocks, entered just after an edge
    task automatic hold(input logic b, input int n);
        line <= b;
        repeat (n) @(posedge clk);
    endtask
    // start, data, optional parity, stop
    task automatic send(input logic [8:0] w, input int nb, input logic pen,
                        input logic pb, input int gap);
        repeat (gap) @(posedge clk);
        hold(1'b0, BIT_CYC);
        for (int i = 0; i < nb; i++) hold(w[i], BIT_CYC);
        if (pen) hold(pb, BIT_CYC);
        hold(1'b1, BIT_CYC);
    endtask
    // short falling pulse, enough to wake a stopped receiver
    task automatic pulse_low(input int n);
        hold(1'b0, n);
        hold(1'b1, 1);
    endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the serial interrupt block
// Assumes: baud divisor 0, so one bit is 16 clocks
// Notes: pulse counters judge interrupts, vectors and wake-ups
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin \
    num_errors++; $display("mismatch at %0t: got %0h exp %0h", $time, \
    g, x); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STARTUP = 10;
    localparam logic [7:0] A_ST = uirq_pkg::UIRQ_STATUS_ADDR;
    localparam logic [7:0] A_C1 = uirq_pkg::UIRQ_CTRL1_ADDR;
    localparam logic [7:0] A_C2 = uirq_pkg::UIRQ_CTRL2_ADDR;
    localparam logic [7:0] A_SY = uirq_pkg::UIRQ_SYS_ADDR;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic tx_empty_in = 1'b0;
    logic tx_idle_in = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq_n, vector_req, wake_out, rx_line, err;
    logic [11:0] e;
    // {nine, addr detect, irq expected, word}
    logic [11:0] adt [5] = '{12'h405, 12'h685, 12'h205, 12'hC80, 12'hF00};
    // {ctrl2, sys, idle source, irq expected, vector expected}
    logic [11:0] txt [5] = '{12'h81B, 12'h80A, 12'h83A, 12'h01C, 12'h41F};
    int num_errors = 0;
    int comparisons = 0;
    int irqs = 0, vecs = 0, wakes = 0, b0, b1;
    always #50 pclk = ~pclk;
    uirq_top #(.STARTUP_CYC(STARTUP)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_in(rx_line), .tx_empty_in(tx_empty_in),
        .tx_idle_in(tx_idle_in), .irq_n(irq_n), .vector_req(vector_req),
        .wake_out(wake_out));
    uirq_rx_driver #(.BIT_CYC(16)) rxd (.clk(pclk), .line(rx_line));
    ////////////////////////////////////////////////////////////////////////
    // count one-cycle pulses from the block
    always @(posedge pclk) begin
        if (irq_n === 1'b0) irqs++;
        if (vector_req === 1'b1) vecs++;
        if (wake_out === 1'b1) wakes++;
    end
    // one apb transfer; a fresh edge first keeps back-to-back calls clean
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        `CHK(n < 20, 1'b1)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(rd, 32'h00000000)
        end
        apb(1'b1, A_ST, 32'h000000FF);
        apb(1'b0, A_ST, 32'h0);
        `CHK(rd, 32'h00000000)
        apb(1'b0, 8'h18, 32'h0);
        `CHK(err, 1'b1)
        $display("test registers done");
        // even parity, first word carries a wrong parity bit
        apb(1'b1, A_C1, 32'h0000000B);
        apb(1'b1, A_C2, 32'h00000001);
        rxd.send(9'h001, 8, 1'b1, 1'b0, 0);
        repeat (40) @(posedge pclk);
        apb(1'b0, A_ST, 32'h0);
        `CHK(rd[3:0], 4'h9)
        apb(1'b0, uirq_pkg::UIRQ_DATA_ADDR, 32'h0);
        `CHK(rd[8:0], 9'h001)
        apb(1'b0, A_ST, 32'h0);
        `CHK(rd[3], 1'b0)
        rxd.send(9'h003, 8, 1'b1, 1'b0, 20);
        repeat (40) @(posedge pclk);
        apb(1'b0, A_ST, 32'h0);
        `CHK(rd[3:0], 4'h8)
        apb(1'b0, uirq_pkg::UIRQ_DATA_ADDR, 32'h0);
        $display("test parity done");
        // address qualification in eight and nine bit words, parity off
        for (int i = 0; i < 5; i++) begin
            e = adt[i];
            apb(1'b1, A_C1, {29'h0, e[11], 2'b11});
            apb(1'b1, A_C2, {28'h0, 2'b10, e[10], 1'b1});
            b0 = irqs;
            rxd.send(e[8:0], e[11] ? 9 : 8, 1'b0, 1'b0, i * 7);
            repeat (40) @(posedge pclk);
            `CHK(irqs - b0, int'(e[9]))
            apb(1'b0, A_C1, 32'h0);
            `CHK(rd[5], e[8])
            apb(1'b0, A_ST, 32'h0);
            apb(1'b0, uirq_pkg::UIRQ_DATA_ADDR, 32'h0);
            `CHK(rd[7:0], e[7:0])
        end
        $display("test address detect done");
        // overrun: third word with two unread; only the overrun interrupts
        b0 = irqs;
        for (int i = 1; i < 4; i++) rxd.send(9'(8'h11 * i), 9, 1'b0, 1'b0, 0);
        repeat (40) @(posedge pclk);
        `CHK(irqs - b0, 1)
        apb(1'b0, A_ST, 32'h0);
        `CHK(rd[3:0], 4'hC)
        apb(1'b0, uirq_pkg::UIRQ_DATA_ADDR, 32'h0);
        `CHK(rd[7:0], 8'h11)
        apb(1'b0, A_ST, 32'h0);
        `CHK(rd[3:0], 4'h8)
        apb(1'b0, uirq_pkg::UIRQ_DATA_ADDR, 32'h0);
        `CHK(rd[7:0], 8'h22)
        $display("test overrun done");
        // transmit sources, their enables and the vector gate
        for (int i = 0; i < 5; i++) begin
            e = txt[i];
            apb(1'b1, A_C2, {26'h0, e[11:6]});
            apb(1'b1, A_SY, {29'h0, e[5:3]});
            repeat (5) @(posedge pclk);
            b0 = irqs;
            b1 = vecs;
            if (e[2]) tx_idle_in <= 1'b1;
            else tx_empty_in <= 1'b1;
            repeat (10) @(posedge pclk);
            `CHK(irqs - b0, int'(e[1]))
            `CHK(vecs - b1, int'(e[0]))
            tx_empty_in <= 1'b0;
            tx_idle_in <= 1'b0;
        end
        $display("test transmit sources done");
        // wake from a stopped clock, with and without global enables
        apb(1'b1, A_C1, 32'h00000003);
        apb(1'b1, A_C2, 32'h0000000D);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, A_SY, i ? 32'h8 : 32'hB);
            b0 = irqs;
            b1 = wakes;
            rxd.pulse_low(2);
            repeat (STARTUP + 30) @(posedge pclk);
            `CHK(wakes - b1, 1)
            `CHK(irqs - b0, 1 - i)
            apb(1'b1, A_SY, 32'h0);
            apb(1'b0, A_C2, 32'h0);
            `CHK(rd[7:0], 8'h0D)
        end
        apb(1'b0, A_ST, 32'h0);
        `CHK(rd[3], 1'b0)
        $display("test wake done");
        print_verdict;
    end
    // cut a hang short well beyond the expected run
    initial begin
        repeat (30000) @(posedge pclk);
        num_errors++;
        $display("mismatch at %0t: timeout", $time);
        print_verdict;
    end
endmodule
